// ---- inc/pmd_pkg.sv ----
// Constants and types shared by the mode and data image logic.
package pmd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Image geometry and byte addresses.
	localparam int unsigned IMG_BYTES   = 16;
	localparam logic [3:0]  ADR_MODE    = 4'h0;
	localparam logic [3:0]  ADR_CARD    = 4'h1;
	localparam logic [3:0]  ADR_DOUT    = 4'h2;
	localparam logic [3:0]  ADR_DIN_LO  = 4'h2;
	localparam logic [3:0]  ADR_DIN_HI  = 4'h3;
	localparam logic [3:0]  ADR_SUPPLY  = 4'h5;
	localparam logic [3:0]  ADR_OVLD    = 4'h7;
	localparam logic [3:0]  ADR_DCARD   = 4'h8;
	localparam logic [3:0]  ADR_ENC_ST1 = 4'ha;
	localparam logic [3:0]  ADR_ENC_CTL = 4'hb;
	localparam logic [3:0]  ADR_ENC_ST2 = 4'hb;
	localparam logic [3:0]  ADR_ENC_VAL = 4'hc;
	localparam logic [3:0]  ADR_ENC_V16 = 4'he;
	localparam logic [3:0]  ADR_APP_LO  = 4'h2;

	////////////////////////////////////////////////////////////////////////
	// Mode commands, status codes and bit positions.
	localparam logic [3:0] CMD_KEEP     = 4'h0;
	localparam logic [3:0] CMD_NRM_STOP = 4'h1;
	localparam logic [3:0] CMD_NRM_RUN  = 4'h2;
	localparam logic [3:0] CMD_DBG_STOP = 4'h5;
	localparam logic [3:0] CMD_DBG_RUN  = 4'h6;
	localparam logic [3:0] CMD_SS_IDLE  = 4'h8;
	localparam logic [3:0] CMD_SS_SCAN  = 4'ha;
	localparam logic [3:0] STS_SSCAN    = 4'ha;
	localparam int unsigned BIT_RUN      = 1;
	localparam int unsigned BIT_SINGLE   = 3;
	localparam int unsigned BIT_BUSY     = 6;
	localparam int unsigned ENC_SIZE_BIT = 0;
	localparam logic [7:0]  ENC_CTL_MASK = 8'h07;

	////////////////////////////////////////////////////////////////////////
	// Program-card status codes.
	localparam logic [2:0] CARD_GOOD     = 3'h0;
	localparam logic [2:0] CARD_NONE     = 3'h1;
	localparam logic [2:0] CARD_BAD      = 3'h2;
	localparam logic [2:0] CARD_NOPROG   = 3'h3;
	localparam logic [2:0] CARD_CORRUPT  = 3'h4;
	localparam logic [2:0] CARD_MISMATCH = 3'h7;

	////////////////////////////////////////////////////////////////////////
	// Operating modes, one-hot.
	typedef enum logic [4:0] {
		MODE_NRM_STOP = 5'b00001,
		MODE_NRM_RUN  = 5'b00010,
		MODE_DBG_STOP = 5'b00100,
		MODE_DBG_RUN  = 5'b01000,
		MODE_SSCAN    = 5'b10000
	} pmd_mode_type;

	////////////////////////////////////////////////////////////////////////
	// Carriers and state records.
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
		logic       valid;
	} pmd_wr_type;

	typedef struct packed {
		logic [14:0] din;
		logic [3:0]  supply;
		logic [7:0]  overload;
	} pmd_pins_type;

	typedef struct packed {
		logic        card_err;
		logic        enc_sel;
		logic [7:0]  enc_stat2;
		logic [31:0] enc_value;
	} pmd_core_type;

	typedef struct packed {
		pmd_pins_type          s1;
		pmd_pins_type          s2;
		logic [15:0][7:0]      out_img;
		pmd_mode_type          mode;
		logic                  run_prev;
		logic [3:0]            walk;
		logic [7:0]            dout;
		logic [2:0]            enc_ctrl;
		logic [31:0]           enc_preset;
		logic [111:0]          app_out;
		logic                  scan;
		logic                  run;
	} pmd_state_type;

	typedef struct packed {
		logic [15:0][7:0] mem;
		logic [7:0]       rdata;
	} pmd_ram_type;

	localparam pmd_mode_type  MODE_RST = MODE_NRM_STOP;
	localparam pmd_state_type ST_RST   = '{mode: MODE_RST, default: '0};
	localparam pmd_ram_type   RAM_RST  = '0;

endpackage : pmd_pkg

// ---- design/pmd_image_ram.sv ----
// Sixteen-byte input image memory with a registered read port.
`timescale 1ns/1ns
module pmd_image_ram (
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Write port.
	input  wire logic       i_we,
	input  wire logic [3:0] i_waddr,
	input  wire logic [7:0] i_wdata,
	// Read port.
	input  wire logic [3:0] i_raddr,
	output logic      [7:0] o_rdata
);
	import pmd_pkg::*;

	pmd_ram_type r;
	pmd_ram_type n;

	// A read in the cycle of a write to the same byte returns the old value.
	always_comb begin
		n = r;
		n.rdata = r.mem[i_raddr];
		if (i_we) begin
			n.mem[i_waddr] = i_wdata;
		end
	end

	// State register.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			r <= RAM_RST;
		end else begin
			r <= n;
		end
	end

	assign o_rdata = r.rdata;

endmodule : pmd_image_ram

// ---- design/pmd_mode_data.sv ----
// Mode command decoder and sixteen-byte process image of the module.
//
// Operation
// [R1] Sixteen input bytes offered and sixteen output bytes taken every exchange.
// [R2] Output bytes 0 and 1 are commands; input bytes 0 and 1 are status.
// [R3] Normal mode passes bytes 2 to 15 unchanged both ways.
// [R4] Debug: output byte 2 drives outputs; input bytes 2, 3 show inputs.
// [R5] Debug: supply, overloads, card and encoder status at bytes 5,7,8,10,11.
// [R6] Debug: output byte 11 encoder control, bytes 12-15 preset, MSB first.
// [R7] Debug: encoder data in bytes 12-15, LSB at 15; 16-bit from 14.
// [R8] Mode command in bits 3..0 of byte 0; other command bits reserved.
// [R9] Command 0000 keeps state, 0001 normal stop, 0010 normal run.
// [R10] 0101 debug stop with outputs off, 0110 debug run; status echoes them.
// [R11] 1010 single scan with one scan; 1000 single-scan idle, no scan.
// [R12] With single bit set, one scan per 0 to 1 change of run bit.
// [R13] Status bits 3..0: 0001 stopped, 0010 running, 1010 single scan.
// [R14] Busy bit 6 set while unable; no I/O or diagnostic update then.
// [R15] Card code: 000 good, 001 absent, 010 bad or invalid.
// [R16] Card code 011 no program, 100 corrupted, 111 mismatch only if native.
// [R17] Master changes modes only through the command byte; data per program.
// [R18] Master exchanges the image over the fieldbus through the rack adapter.
// [R19] Master writes reserved bits as zero; status reserved bits read zero.
// [R20] Undefined command codes leave the mode and status unchanged.
`timescale 1ns/1ns
module pmd_mode_data (
	// Clock and reset.
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	// Master side of the cyclic image.
	input  wire pmd_pkg::pmd_wr_type   i_wr,
	input  wire logic                  i_cycle_end,
	input  wire logic [3:0]            i_rd_addr,
	output logic      [7:0]            o_rd_data,
	// Module core status.
	input  wire logic                  i_busy,
	input  wire logic [2:0]            i_card,
	input  wire logic                  i_native,
	input  wire pmd_pkg::pmd_core_type i_core,
	// User program side.
	input  wire logic [111:0]          i_app_in,
	input  wire logic [7:0]            i_prog_dout,
	output logic      [111:0]          o_app_out,
	output logic                       o_prog_run,
	output logic                       o_scan,
	// Field pins and encoder control.
	input  wire pmd_pkg::pmd_pins_type i_pins,
	output logic      [7:0]            o_dout,
	output logic      [2:0]            o_enc_ctrl,
	output logic      [31:0]           o_enc_preset
);
	import pmd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Status code that the mode reports.
	function automatic logic [3:0] status_of(input pmd_mode_type m);
		logic [3:0] s;
		s = CMD_NRM_STOP;
		case (m)
		MODE_NRM_RUN: s = CMD_NRM_RUN;
		MODE_DBG_STOP: s = CMD_DBG_STOP;
		MODE_DBG_RUN: s = CMD_DBG_RUN;
		MODE_SSCAN: s = STS_SSCAN;
		default: s = CMD_NRM_STOP;
		endcase
		return s;
	endfunction : status_of

	// True in either debug mode.
	function automatic logic is_debug(input pmd_mode_type m);
		return (m == MODE_DBG_STOP) || (m == MODE_DBG_RUN);
	endfunction : is_debug

	// True for every defined command code.
	function automatic logic cmd_known(input logic [3:0] c);
		return (c == CMD_KEEP) || (c == CMD_NRM_STOP) ||
			(c == CMD_NRM_RUN) || (c == CMD_DBG_STOP) ||
			(c == CMD_DBG_RUN) || (c == CMD_SS_IDLE) ||
			(c == CMD_SS_SCAN);
	endfunction : cmd_known

	// Application byte for image address a (byte 2 sits lowest).
	function automatic logic [7:0] app_byte(input logic [111:0] d,
		input logic [3:0] a);
		logic [6:0] sh;
		sh = {a - ADR_APP_LO, 3'b000};
		return d[sh +: 8];
	endfunction : app_byte

	// Big-endian byte of a word placed at bytes 12 to 15.
	function automatic logic [7:0] word_byte(input logic [31:0] w,
		input logic [3:0] a);
		logic [3:0] k;
		logic [4:0] sh;
		k = 4'hf - a;
		sh = {k[1:0], 3'b000};
		return w[sh +: 8];
	endfunction : word_byte

	////////////////////////////////////////////////////////////////////////
	// State and combinational helpers.
	pmd_state_type r;
	pmd_state_type n;
	logic [3:0]    cmd;
	logic          take;
	logic [2:0]    card_code;
	logic [3:0]    stat_now;
	logic [31:0]   word;
	logic [7:0]    in_byte;
	logic          ram_we;
	logic          dbg;

	// A command counts only at a bus-cycle boundary while not busy.
	assign cmd  = r.out_img[ADR_MODE][3:0]; // R8
	assign take = i_cycle_end && !i_busy; // R14

	// Mismatch is only meaningful to a native master.
	assign card_code = (i_card == CARD_MISMATCH && !i_native) ?
		CARD_GOOD : i_card; // R16
	assign stat_now = status_of(r.mode); // R13

	////////////////////////////////////////////////////////////////////////
	// Next-state logic: image capture, mode machine, outputs, input walk.
	always_comb begin
		n = r;
		dbg = 1'b0;
		in_byte = 8'h00;
		ram_we = 1'b0;
		word = 32'h0000_0000;
		n.s1 = i_pins;
		n.s2 = r.s1;
		n.scan = 1'b0;
		n.walk = r.walk + 4'h1;
		// Output image bytes are refused while busy.
		if (i_wr.valid && !i_busy) begin // R14
			n.out_img[i_wr.addr] = i_wr.data; // R1 R2
		end
		// Mode machine, stepped once per exchange.
		if (take) begin
			n.run_prev = cmd[BIT_RUN]; // R12
			case (cmd)
			CMD_KEEP: n.mode = r.mode; // R9
			CMD_NRM_STOP: n.mode = MODE_NRM_STOP; // R9
			CMD_NRM_RUN: n.mode = MODE_NRM_RUN; // R9
			CMD_DBG_STOP: n.mode = MODE_DBG_STOP; // R10
			CMD_DBG_RUN: n.mode = MODE_DBG_RUN; // R10
			CMD_SS_IDLE: n.mode = MODE_SSCAN; // R11
			CMD_SS_SCAN: begin
				n.mode = MODE_SSCAN; // R11
				n.scan = cmd[BIT_SINGLE] && !r.run_prev; // R12
			end
			default: n.mode = r.mode; // R20
			endcase
		end
		n.run = (n.mode == MODE_NRM_RUN) || (n.mode == MODE_DBG_RUN);
		// Outputs freeze while busy.
		if (!i_busy) begin // R14
			if (n.mode == MODE_DBG_RUN) begin
				n.dout = r.out_img[ADR_DOUT]; // R4
			end else if (n.mode == MODE_DBG_STOP) begin
				n.dout = 8'h00; // R10
			end else begin
				n.dout = i_prog_dout;
			end
			if (is_debug(n.mode)) begin
				n.enc_ctrl = r.out_img[ADR_ENC_CTL][2:0] &
					ENC_CTL_MASK[2:0]; // R6
				n.enc_preset = {r.out_img[ADR_ENC_VAL],
					r.out_img[ADR_ENC_VAL + 4'h1],
					r.out_img[ADR_ENC_V16],
					r.out_img[ADR_ENC_V16 + 4'h1]}; // R6
			end else begin
				n.enc_ctrl = 3'h0;
				n.app_out = r.out_img[15:2]; // R3
			end
		end
		// Compose the input byte at the walk address.
		dbg = is_debug(r.mode);
		word = i_core.enc_stat2[ENC_SIZE_BIT] ? i_core.enc_value :
			{16'h0000, i_core.enc_value[15:0]}; // R7
		if (r.walk == ADR_MODE) begin
			in_byte = {1'b0, i_busy, 2'b00, stat_now}; // R13 R14 R19
		end else if (r.walk == ADR_CARD) begin
			in_byte = {5'h00, card_code}; // R15 R16 R19
		end else if (!dbg) begin
			in_byte = app_byte(i_app_in, r.walk); // R3
		end else if (r.walk == ADR_DIN_LO) begin
			in_byte = r.s2.din[7:0]; // R4
		end else if (r.walk == ADR_DIN_HI) begin
			in_byte = {1'b0, r.s2.din[14:8]}; // R4
		end else if (r.walk == ADR_SUPPLY) begin
			in_byte = {r.s2.supply, 4'h0}; // R5
		end else if (r.walk == ADR_OVLD) begin
			in_byte = r.s2.overload; // R5
		end else if (r.walk == ADR_DCARD) begin
			in_byte = {i_core.card_err, 7'h00}; // R5
		end else if (r.walk == ADR_ENC_ST1) begin
			in_byte = {7'h00, i_core.enc_sel}; // R5
		end else if (r.walk == ADR_ENC_ST2) begin
			in_byte = i_core.enc_stat2; // R5
		end else if (r.walk >= ADR_ENC_VAL) begin
			in_byte = word_byte(word, r.walk); // R7
		end else begin
			in_byte = 8'h00;
		end
		// Only the two status bytes refresh while busy.
		ram_we = !i_busy || (r.walk <= ADR_CARD); // R14
	end

	// State register.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			r <= ST_RST;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input image memory read by the master.
	pmd_image_ram u_in_img (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_we    (ram_we),
		.i_waddr (r.walk),
		.i_wdata (in_byte),
		.i_raddr (i_rd_addr),
		.o_rdata (o_rd_data)
	); // R1

	// Outputs come straight from the state register.
	assign o_app_out    = r.app_out;
	assign o_prog_run   = r.run;
	assign o_scan       = r.scan;
	assign o_dout       = r.dout;
	assign o_enc_ctrl   = r.enc_ctrl;
	assign o_enc_preset = r.enc_preset;

	////////////////////////////////////////////////////////////////////////
	// Assertions and covers.
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	property p_run_cmd;
		take && cmd == CMD_NRM_RUN |=>
			r.mode == MODE_NRM_RUN && o_prog_run;
	endproperty
	a_run_cmd: assert property (p_run_cmd) // R9
		else $error("normal run command not taken");

	property p_dbg_off;
		take && cmd == CMD_DBG_STOP |=> o_dout == 8'h00;
	endproperty
	a_dbg_off: assert property (p_dbg_off) // R10
		else $error("outputs not off in debug stop");

	property p_idle;
		take && cmd == CMD_SS_IDLE |=> r.mode == MODE_SSCAN && !o_scan;
	endproperty
	a_idle: assert property (p_idle) // R11
		else $error("single-scan idle misbehaved");

	property p_scan_once;
		take && cmd == CMD_SS_SCAN && !r.run_prev |=> o_scan ##1 !o_scan;
	endproperty
	a_scan_once: assert property (p_scan_once) // R12
		else $error("single scan not one pulse");

	property p_undef;
		take && !cmd_known(cmd) |=> $stable(r.mode);
	endproperty
	a_undef: assert property (p_undef) // R20
		else $error("undefined command changed the mode");

	property p_busy_hold;
		i_busy |=> $stable(o_dout) && $stable(o_enc_preset);
	endproperty
	a_busy_hold: assert property (p_busy_hold) // R14
		else $error("outputs changed while busy");

	property p_status_read;
		r.walk == ADR_MODE ##1 i_rd_addr == ADR_MODE |=>
			o_rd_data[3:0] == $past(stat_now, 2) &&
			o_rd_data[BIT_BUSY] == $past(i_busy, 2);
	endproperty
	a_status_read: assert property (p_status_read) // R13
		else $error("status byte does not match mode");

	property p_reserved;
		r.walk == ADR_MODE ##1 i_rd_addr == ADR_MODE |=>
			o_rd_data[7] == 1'b0 && o_rd_data[5:4] == 2'b00;
	endproperty
	a_reserved: assert property (p_reserved) // R19
		else $error("reserved status bit not zero");

	property p_preset;
		is_debug(r.mode) && !i_busy && !i_cycle_end |=>
			o_enc_preset[31:24] == $past(r.out_img[ADR_ENC_VAL]);
	endproperty
	a_preset: assert property (p_preset) // R6
		else $error("preset MSB not from byte twelve");

	c_dbg_run: cover property (take && cmd == CMD_DBG_RUN);
	c_scan: cover property (o_scan);
	c_busy: cover property (i_busy ##1 !i_busy);
	c_sscan: cover property (r.mode == MODE_SSCAN);

endmodule : pmd_mode_data

// ---- verification/pmd_master_model.sv ----
// Fieldbus master model that exchanges the cyclic image byte by byte.
`timescale 1ns/1ns
module pmd_master_model (
	// Clock.
	input  wire logic               i_clk,
	// Image port towards the module.
	output pmd_pkg::pmd_wr_type     o_wr,
	output logic                    o_cycle_end,
	output logic [3:0]              o_rd_addr,
	input  wire logic [7:0]         i_rd_data
);
	import pmd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Idle levels from time zero.
	initial begin
		o_wr        = '0;
		o_cycle_end = 1'b0;
		o_rd_addr   = 4'h0;
	end

	// One output byte, valid for exactly one cycle.
	task automatic put(input logic [3:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_wr = '{addr: a, data: d, valid: 1'b1};
		@(negedge i_clk);
		o_wr.valid = 1'b0;
	endtask : put

	// Mode change only through the command byte, reserved bits zero.
	task automatic cmd(input logic [3:0] c);
		put(ADR_MODE, {4'h0, c});
		o_cycle_end = 1'b1;
		@(negedge i_clk);
		o_cycle_end = 1'b0;
	endtask : cmd

	// Input byte read, data taken one cycle after the address.
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_rd_addr = a;
		@(negedge i_clk);
		d = i_rd_data;
	endtask : rd

endmodule : pmd_master_model

// ---- verification/tb_pmd_mode_data.sv ----
// Self-checking bench of the mode decoder and process image.
`timescale 1ns/1ns
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin \
	err_total++; $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module tb_pmd_mode_data;
	import pmd_pkg::*;

	logic          i_clk;
	logic          i_rst;
	pmd_wr_type    wr;
	logic          cyc_end;
	logic [3:0]    rd_addr;
	logic [7:0]    rd_data;
	logic          busy;
	logic [2:0]    card;
	logic          native;
	pmd_core_type  core;
	logic [111:0]  app_in;
	logic [7:0]    prog_dout;
	logic [111:0]  app_out;
	logic          prog_run;
	logic          scan;
	pmd_pins_type  pins;
	logic [7:0]    dout;
	logic [2:0]    enc_ctrl;
	logic [31:0]   enc_preset;
	int            err_total;
	int            cmp_count;
	int            scans;
	int            cyc;
	logic [7:0]    b;

	////////////////////////////////////////////////////////////////////////
	// Design and master model.
	pmd_mode_data i_pmd_mode_data (.i_clk(i_clk), .i_rst(i_rst), .i_wr(wr),
		.i_cycle_end(cyc_end), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
		.i_busy(busy), .i_card(card), .i_native(native), .i_core(core),
		.i_app_in(app_in), .i_prog_dout(prog_dout), .o_app_out(app_out),
		.o_prog_run(prog_run), .o_scan(scan), .i_pins(pins), .o_dout(dout),
		.o_enc_ctrl(enc_ctrl), .o_enc_preset(enc_preset));
	pmd_master_model i_pmd_master_model (.i_clk(i_clk), .o_wr(wr),
		.o_cycle_end(cyc_end), .o_rd_addr(rd_addr), .i_rd_data(rd_data));

	// Clock, scan pulse counter and hang guard.
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (scan === 1'b1) scans++;
		if (cyc == 40000) begin
			err_total++;
			summarize();
		end
	end

	// Verdict printed once, from here only.
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// Command, then wait for the input image walk to pass.
	task automatic go(input logic [3:0] c);
		i_pmd_master_model.cmd(c);
		repeat (24) @(negedge i_clk);
	endtask : go

	task automatic rb(input logic [3:0] a, output logic [7:0] d);
		i_pmd_master_model.rd(a, d);
	endtask : rb

	////////////////////////////////////////////////////////////////////////
	// Main sequence with integer reference model.
	initial begin
		static logic [3:0] cl[11] = '{4'h2, 4'h0, 4'h3, 4'h1, 4'h5, 4'h6,
			4'h8, 4'ha, 4'ha, 4'h8, 4'ha};
		static logic [2:0] cc[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
		logic [7:0] ob[16];
		int sts, prv, xs, k;
		{busy, card, native, core, app_in, pins} = '0;
		prog_dout = 8'h5a;
		err_total = 0;
		cmp_count = 0;
		scans = 0;
		cyc = 0;
		sts = 1;
		prv = 0;
		xs = 0;
		i_rst = 1'b1;
		void'($urandom(32'hbef8));
		repeat (20) @(negedge i_clk);
		i_rst = 1'b0;
		go(4'h0);
		rb(ADR_MODE, b);
		`CHK("reset status", 8'h01, b)
		// Every mode command, a keep and an undefined code.
		for (int i = 0; i < 11; i++) begin
			if (cl[i] inside {4'h1, 4'h2, 4'h5, 4'h6, 4'h8, 4'ha})
				sts = cl[i][3] ? 4'ha : cl[i];
			if (cl[i] == 4'ha && prv == 0) xs++;
			prv = cl[i][1];
			go(cl[i]);
			rb(ADR_MODE, b);
			`CHK("status", 8'(sts), b)
			`CHK("run", sts == 2 || sts == 6, prog_run)
			`CHK("scans", xs, scans)
			// Output byte 2 is still zero here, so debug run drives zero.
			`CHK("dout", (sts == 5 || sts == 6) ? 8'h00 : prog_dout, dout)
		end
		$display("test modes done");
		// Card codes for native and other masters.
		for (int n = 0; n < 2; n++)
			for (int i = 0; i < 6; i++) begin
				native = n[0];
				card = cc[i];
				repeat (20) @(negedge i_clk);
				rb(ADR_CARD, b);
				`CHK("card", (cc[i] == 7 && n == 0) ? 8'h00 : 8'(cc[i]), b)
			end
		$display("test card done");
		// Busy refuses commands and shows bit 6.
		go(4'h1);
		busy = 1'b1;
		go(4'h2);
		rb(ADR_MODE, b);
		`CHK("busy status", 8'h41, b)
		`CHK("busy run", 1'b0, prog_run)
		busy = 1'b0;
		$display("test busy done");
		// Normal mode passes free-form bytes both ways.
		go(4'h2);
		for (k = 0; k < 14; k++) begin
			app_in[8*k+:8] = 8'($urandom);
			ob[k] = 8'($urandom);
			i_pmd_master_model.put(4'(k + 2), ob[k]);
		end
		go(4'h0);
		for (k = 0; k < 14; k++) begin
			rb(4'(k + 2), b);
			`CHK("app in", app_in[8*k+:8], b)
			`CHK("app out", ob[k], app_out[8*k+:8])
		end
		`CHK("prog dout", prog_dout, dout)
		$display("test normal done");
		// Debug layout with random pins, 16 and 32 bit encoder.
		for (int sz = 0; sz < 2; sz++) begin
			pins = pmd_pins_type'({$urandom, $urandom});
			core = pmd_core_type'({$urandom, $urandom});
			core.enc_stat2[0] = sz[0];
			for (k = 2; k < 16; k++) begin
				ob[k] = 8'($urandom);
				i_pmd_master_model.put(4'(k), ob[k]);
			end
			go(4'h6);
			`CHK("dbg dout", ob[2], dout)
			`CHK("enc ctl", ob[11][2:0], enc_ctrl)
			`CHK("preset", {ob[12], ob[13], ob[14], ob[15]}, enc_preset)
			rb(4'h2, b); `CHK("din lo", pins.din[7:0], b)
			rb(4'h3, b); `CHK("din hi", {1'b0, pins.din[14:8]}, b)
			rb(4'h5, b); `CHK("supply", {pins.supply, 4'h0}, b)
			rb(4'h7, b); `CHK("ovld", pins.overload, b)
			rb(4'h8, b); `CHK("dcard", {core.card_err, 7'h0}, b)
			rb(4'ha, b); `CHK("enc st1", {7'h0, core.enc_sel}, b)
			rb(4'hb, b); `CHK("enc st2", core.enc_stat2, b)
			for (k = 0; k < 4; k++) begin
				rb(4'(12 + k), b);
				`CHK("enc", (sz == 0 && k < 2) ? 8'h00 :
					core.enc_value[31-8*k-:8], b)
			end
		end
		go(4'h5);
		`CHK("dbg stop dout", 8'h00, dout)
		$display("test debug done");
		summarize();
	end

endmodule : tb_pmd_mode_data
